// >>> hw/tccr_top.sv
// four-channel timer capture/compare registers with prescaler and input capture
`timescale 1ns/100ps
`include "tccr_regs.svh"

module tccr_top
	import tccr_pkg::*;
(
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	// byte register port, offsets relative to the selected base
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [7:0]  reg_wdata_in,
	output      logic [7:0]  reg_rdata_out,
	// capture pins, asynchronous
	input  wire logic [3:0]  capture_pin_in,
	// channel outputs
	output      logic [3:0]  channel_irq_out,
	output      logic [3:0]  compare_match_out,
	output      logic [15:0] free_running_counter_out
);

	// ****************************************
	// state
	// ****************************************
	tccr_word_t                chan_r [`TCCR_NUM_CH];
	tccr_word_t                chan_nxt [`TCCR_NUM_CH];
	logic [3:0]                direction_select_reg_r, direction_select_reg_nxt;
	logic [3:0]                irq_enable_reg_r, irq_enable_reg_nxt;
	logic [3:0]                channel_flag_reg_r, channel_flag_reg_nxt;
	logic [7:0]                edge_ctrl_r, edge_ctrl_nxt;
	logic                      fast_flag_clear_r, fast_flag_clear_nxt;
	logic [2:0]                prescale_select_r, prescale_select_nxt;
	logic [2:0]                presc_active_r, presc_active_nxt;
	logic [`TCCR_PRESC_W-1:0]  presc_cnt_r, presc_cnt_nxt;
	tccr_word_t                free_running_counter_r, free_running_counter_nxt;
	tccr_byte_t                rd_shadow_r, rd_shadow_nxt;
	tccr_byte_t                wr_shadow_r, wr_shadow_nxt;
	tccr_byte_t                rdata_r, rdata_nxt;
	logic [3:0]                sync1_r, sync2_r, pin_prev_r;

	// ****************************************
	// capture edge detection
	// ****************************************
	logic [3:0] cap_event;
	logic [3:0] cmp_event;
	logic [6:0] presc_mask;
	logic       presc_tick;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			sync1_r    <= 4'h0;
			sync2_r    <= 4'h0;
			pin_prev_r <= 4'h0;
		end else begin
			sync1_r    <= capture_pin_in;
			sync2_r    <= sync1_r;
			pin_prev_r <= sync2_r;
		end
	end

	// one detector per channel; only the second sync stage and its delayed copy are compared
	generate
		for (genvar n = 0; n < `TCCR_NUM_CH; n++) begin : g_edge
			logic rise;
			logic fall;
			tccr_edge_t mode;
			assign rise = sync2_r[n] & ~pin_prev_r[n];
			assign fall = ~sync2_r[n] & pin_prev_r[n];
			assign mode = tccr_edge_t'(edge_ctrl_r[2*n+1 -: 2]);
			assign cap_event[n] = ~direction_select_reg_r[n] &
				(((mode == TCCR_EDGE_RISE) & rise) |
				 ((mode == TCCR_EDGE_FALL) & fall) |
				 ((mode == TCCR_EDGE_BOTH) & (rise | fall)));
			assign cmp_event[n] = direction_select_reg_r[n] & presc_tick &
				(free_running_counter_r == chan_r[n]);
		end
	endgenerate

	assign presc_mask = 7'((8'h01 << presc_active_r) - 8'h01);
	assign presc_tick = ((presc_cnt_r & presc_mask) == presc_mask);

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		logic [3:0] flag_clr;
		logic [1:0] ch_idx;
		logic       ch_hit;
		logic       ch_hi;
		flag_clr                 = 4'h0;
		ch_idx                   = 2'h0;
		ch_hit                   = 1'b0;
		ch_hi                    = 1'b0;
		for (int i = 0; i < `TCCR_NUM_CH; i++) begin
			chan_nxt[i] = chan_r[i];
		end
		direction_select_reg_nxt = direction_select_reg_r;
		irq_enable_reg_nxt       = irq_enable_reg_r;
		edge_ctrl_nxt            = edge_ctrl_r;
		fast_flag_clear_nxt      = fast_flag_clear_r;
		prescale_select_nxt      = prescale_select_r;
		presc_active_nxt         = presc_active_r;
		presc_cnt_nxt            = presc_cnt_r + 7'h01;
		free_running_counter_nxt = free_running_counter_r;
		rd_shadow_nxt            = rd_shadow_r;
		wr_shadow_nxt            = wr_shadow_r;
		rdata_nxt                = rdata_r;

		// channel address decode, two bytes per channel
		for (int i = 0; i < `TCCR_NUM_CH; i++) begin
			if (reg_addr_in[7:1] == 7'((`TCCR_OFF_CH0 + 8'(2 * i)) >> 1)) begin
				ch_hit = 1'b1;
				ch_idx = 2'(i);
			end
		end
		ch_hi = ~reg_addr_in[0];

		// divisor switches only when all stages are zero
		if (presc_cnt_r == 7'h00) begin
			presc_active_nxt = prescale_select_r;
		end
		if (presc_tick) begin
			free_running_counter_nxt = free_running_counter_r + 16'h0001;
		end

		// register reads; data appears one cycle after the strobe
		if (reg_rd_in) begin
			rdata_nxt = `TCCR_BYTE_RESET;
			if (ch_hit) begin
				if (ch_hi) begin
					rdata_nxt     = chan_r[ch_idx][15:8];
					rd_shadow_nxt = chan_r[ch_idx][7:0];
				end else begin
					rdata_nxt = rd_shadow_r;
				end
				// fast clear on upper-byte read of a capture channel
				if (ch_hi & fast_flag_clear_r & ~direction_select_reg_r[ch_idx]) begin
					flag_clr[ch_idx] = 1'b1;
				end
			end else begin
				case (reg_addr_in)
					`TCCR_OFF_DIR:  rdata_nxt = {4'h0, direction_select_reg_r};
					`TCCR_OFF_SYS1: rdata_nxt = 8'(fast_flag_clear_r) << `TCCR_SYS1_FFC_BIT;
					`TCCR_OFF_EDGE: rdata_nxt = edge_ctrl_r;
					`TCCR_OFF_IEN:  rdata_nxt = {4'h0, irq_enable_reg_r};
					`TCCR_OFF_SYS2: rdata_nxt = {5'h00, prescale_select_r};
					`TCCR_OFF_FLAG: rdata_nxt = {4'h0, channel_flag_reg_r};
					default:        rdata_nxt = `TCCR_BYTE_RESET;
				endcase
			end
		end

		// register writes
		if (reg_wr_in) begin
			if (ch_hit) begin
				if (direction_select_reg_r[ch_idx]) begin
					// upper byte held until lower byte completes the word
					if (ch_hi) begin
						wr_shadow_nxt = reg_wdata_in;
					end else begin
						chan_nxt[ch_idx] = {wr_shadow_r, reg_wdata_in};
						if (fast_flag_clear_r) begin
							flag_clr[ch_idx] = 1'b1;
						end
					end
				end
			end else begin
				case (reg_addr_in)
					`TCCR_OFF_DIR:  direction_select_reg_nxt = reg_wdata_in[3:0];
					`TCCR_OFF_SYS1: fast_flag_clear_nxt = reg_wdata_in[`TCCR_SYS1_FFC_BIT];
					`TCCR_OFF_EDGE: edge_ctrl_nxt = reg_wdata_in;
					`TCCR_OFF_IEN:  irq_enable_reg_nxt = reg_wdata_in[3:0];
					`TCCR_OFF_SYS2: prescale_select_nxt = reg_wdata_in[`TCCR_SYS2_PR_MSB:`TCCR_SYS2_PR_LSB];
					`TCCR_OFF_FLAG: flag_clr = flag_clr | reg_wdata_in[3:0];
					default:        flag_clr = flag_clr;
				endcase
			end
		end

		// capture the counter, overriding any write
		for (int i = 0; i < `TCCR_NUM_CH; i++) begin
			if (cap_event[i]) begin
				chan_nxt[i] = free_running_counter_r;
			end
		end

		// set wins over a clear in the same cycle
		channel_flag_reg_nxt = (channel_flag_reg_r & ~flag_clr) | cap_event | cmp_event;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int i = 0; i < `TCCR_NUM_CH; i++) begin
				chan_r[i] <= `TCCR_CH_RESET;
			end
			direction_select_reg_r <= 4'h0;
			irq_enable_reg_r       <= 4'h0;
			channel_flag_reg_r     <= 4'h0;
			edge_ctrl_r            <= `TCCR_BYTE_RESET;
			fast_flag_clear_r      <= 1'b0;
			prescale_select_r      <= 3'h0;
			presc_active_r         <= 3'h0;
			presc_cnt_r            <= 7'h00;
			free_running_counter_r <= `TCCR_CH_RESET;
			rd_shadow_r            <= `TCCR_BYTE_RESET;
			wr_shadow_r            <= `TCCR_BYTE_RESET;
			rdata_r                <= `TCCR_BYTE_RESET;
		end else begin
			for (int i = 0; i < `TCCR_NUM_CH; i++) begin
				chan_r[i] <= chan_nxt[i];
			end
			direction_select_reg_r <= direction_select_reg_nxt;
			irq_enable_reg_r       <= irq_enable_reg_nxt;
			channel_flag_reg_r     <= channel_flag_reg_nxt;
			edge_ctrl_r            <= edge_ctrl_nxt;
			fast_flag_clear_r      <= fast_flag_clear_nxt;
			prescale_select_r      <= prescale_select_nxt;
			presc_active_r         <= presc_active_nxt;
			presc_cnt_r            <= presc_cnt_nxt;
			free_running_counter_r <= free_running_counter_nxt;
			rd_shadow_r            <= rd_shadow_nxt;
			wr_shadow_r            <= wr_shadow_nxt;
			rdata_r                <= rdata_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// request gated by enable
	assign channel_irq_out          = channel_flag_reg_r & irq_enable_reg_r;
	assign compare_match_out        = cmp_event;
	assign reg_rdata_out            = rdata_r;
	assign free_running_counter_out = free_running_counter_r;

endmodule : tccr_top

// >>> hw/tccr_regs.svh
// register offsets, field positions, reset values and sizes of the timer capture channel block
`ifndef TCCR_REGS_SVH
`define TCCR_REGS_SVH

// ****************************************
// base addresses of the two access windows
// ****************************************
`define TCCR_BASE_BLOCKING    16'h0200
`define TCCR_BASE_NONBLOCKING 16'h0300

// ****************************************
// register byte offsets
// ****************************************
`define TCCR_OFF_DIR   8'hc0
`define TCCR_OFF_SYS1  8'hc6
`define TCCR_OFF_EDGE  8'hc9
`define TCCR_OFF_IEN   8'hca
`define TCCR_OFF_SYS2  8'hcb
`define TCCR_OFF_FLAG  8'hcc
`define TCCR_OFF_CH0   8'hce
`define TCCR_OFF_CH1   8'hd0
`define TCCR_OFF_CH2   8'hd2
`define TCCR_OFF_CH3   8'hd4

// ****************************************
// field positions
// ****************************************
`define TCCR_SYS1_FFC_BIT 4
`define TCCR_SYS2_PR_LSB  0
`define TCCR_SYS2_PR_MSB  2

// ****************************************
// reset values and sizes
// ****************************************
`define TCCR_CH_RESET   16'h0000
`define TCCR_BYTE_RESET 8'h00
`define TCCR_NUM_CH     4
`define TCCR_PRESC_W    7

`endif

// >>> hw/tccr_pkg.sv
// types shared by the timer capture channel block
package tccr_pkg;

	// edge control encoding, high bit first
	typedef enum logic [1:0] {
		TCCR_EDGE_OFF  = 2'h0,
		TCCR_EDGE_RISE = 2'h1,
		TCCR_EDGE_FALL = 2'h2,
		TCCR_EDGE_BOTH = 2'h3
	} tccr_edge_t;

	typedef logic [15:0] tccr_word_t;
	typedef logic [7:0]  tccr_byte_t;

endpackage : tccr_pkg

// >>> sim/tccr_checker.sv
// concurrent checks on the ports of the timer capture channel block
`timescale 1ns/100ps
module tccr_checker
	import tccr_pkg::*;
(
	// clock, reset and bus
	input wire logic        clock_in,
	input wire logic        rst_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [7:0]  reg_rdata_out,
	// channel outputs
	input wire logic [3:0]  channel_irq_out,
	input wire logic [3:0]  compare_match_out,
	input wire logic [15:0] free_running_counter_out
);
	// ****
	// port checks
	// ****
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	reset_zero_a: assert property (disable iff (1'b0) rst_in |=> free_running_counter_out == 16'h0000 &&
		reg_rdata_out == 8'h00 && channel_irq_out == 4'h0) else $error("outputs not cleared by reset");
	cnt_step_a: assert property ($changed(free_running_counter_out) |->
		free_running_counter_out == $past(free_running_counter_out) + 16'h0001) else $error("counter jumped");
	rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
	unmapped_rd_a: assert property (reg_rd_in && reg_addr_in < 8'hc0 |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	flag_rsvd_a: assert property (reg_rd_in && reg_addr_in == 8'hcc |=> reg_rdata_out[7:4] == 4'h0)
		else $error("flag spare bits set");
	presc_rsvd_a: assert property (reg_rd_in && reg_addr_in == 8'hcb |=> reg_rdata_out[7:3] == 5'h00)
		else $error("prescale spare bits set");
	match_pulse_a: assert property (|compare_match_out |=> (compare_match_out & $past(compare_match_out)) == 4'h0)
		else $error("match longer than a cycle");
	irq_fall_a: assert property (($past(channel_irq_out) & ~channel_irq_out) != 4'h0 |->
		$past(reg_wr_in || reg_rd_in)) else $error("irq dropped by itself");
	// main scenarios reached
	match_seen_c: cover property (|compare_match_out);
	irq_seen_c: cover property (|channel_irq_out);
	unmapped_seen_c: cover property (reg_rd_in && reg_addr_in < 8'hc0);
endmodule : tccr_checker

bind tccr_top tccr_checker u_chk (.clock_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.channel_irq_out, .compare_match_out, .free_running_counter_out);

// >>> sim/tccr_pin_model.sv
// capture pin source standing in for the external signals
`timescale 1ns/100ps
module tccr_pin_model (
	// clock and reset
	input wire logic  clock_in,
	input wire logic  rst_in,
	// pins toward the block, idle low
	output logic [3:0] pin_out
);
	// ****
	// pin driver
	// ****
	logic [15:0] cnt_r;
	initial pin_out = 4'h0;
	// mirror of the free-running count, only valid while divide is one
	always_ff @(posedge clock_in) begin
		cnt_r <= rst_in ? 16'h0000 : cnt_r + 16'h0001;
	end
	task automatic pulse(input int ch, input int w, output logic [15:0] r, output logic [15:0] f);
		@(posedge clock_in);
		pin_out[ch] <= 1'b1;
		#1 r = cnt_r + 16'h0002;
		repeat ((w < 3) ? 3 : w) @(posedge clock_in);
		pin_out[ch] <= 1'b0;
		#1 f = cnt_r + 16'h0002;
	endtask : pulse
endmodule : tccr_pin_model

// >>> sim/tb.sv
// self-checking bench of the timer capture channel block
`timescale 1ns/100ps
module tb
	import tccr_pkg::*;
;
	// ****
	// bench
	// ****
	logic        clock_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [7:0]  reg_addr_in = 8'h00;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [7:0]  reg_wdata_in = 8'h00;
	logic [7:0]  reg_rdata_out;
	logic [3:0]  capture_pin_in, channel_irq_out, compare_match_out;
	logic [15:0] free_running_counter_out;
	tccr_word_t  r, f, v, prev;
	tccr_byte_t  d;
	int          error_cnt = 0;
	int          checked = 0;
	always #2 clock_in = ~clock_in;
	tccr_top DUT (.clock_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
		.capture_pin_in, .channel_irq_out, .compare_match_out, .free_running_counter_out);
	tccr_pin_model pins (.clock_in, .rst_in, .pin_out(capture_pin_in));
	task automatic cmp16(input tccr_word_t got, input tccr_word_t exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp16
	// strobe held one edge, data read once settled
	task automatic rd8(input tccr_byte_t a, output tccr_byte_t q);
		@(posedge clock_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		#1 q = reg_rdata_out;
	endtask : rd8
	task automatic wr8(input tccr_byte_t a, input tccr_byte_t b);
		@(posedge clock_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= b;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask : wr8
	task automatic rd16(input tccr_byte_t a, output tccr_word_t q);
		rd8(a, q[15:8]);
		rd8(a + 8'h01, q[7:0]);
	endtask : rd16
	task automatic wr16(input tccr_byte_t a, input tccr_word_t w);
		wr8(a, w[15:8]);
		wr8(a + 8'h01, w[7:0]);
	endtask : wr16
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// whole run is about 4400 cycles
	initial begin
		#100000;
		error_cnt++;
		final_report();
	end
	initial begin
		void'($urandom(32'h7605));
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd16(8'hce + 8'(2 * i), v);
			cmp16(v, 16'h0000);
		end
		rd8(8'h10, d);
		cmp16(16'(d), 16'h0000);
		cmp16(free_running_counter_out, pins.cnt_r);
		$display("test reset done");
		// channels 2 and 3 compare, 0 and 1 capture
		wr8(8'hc0, 8'h0c);
		// top bit forced so the counter never reaches this value during the run
		v = 16'($urandom) | 16'h8000;
		wr16(8'hce, v);
		rd16(8'hce, prev);
		cmp16(prev, 16'h0000);
		wr16(8'hd2, v);
		rd16(8'hd2, r);
		cmp16(r, v);
		$display("test direction done");
		// every edge mode on channel 0, random pulse width
		for (int m = 0; m < 4; m++) begin
			wr8(8'hc9, 8'(m));
			wr8(8'hcc, 8'h01);
			pins.pulse(0, 3 + int'($urandom % 4), r, f);
			repeat (5) @(posedge clock_in);
			rd8(8'hcc, d);
			cmp16(16'(d[0]), 16'(m != 0));
			prev = (m == 0) ? prev : (m == 1) ? r : f;
			rd16(8'hce, v);
			cmp16(v, prev);
		end
		cmp16(16'(channel_irq_out), 16'h0000);
		wr8(8'hca, 8'h01);
		#1 cmp16(16'(channel_irq_out), 16'h0001);
		wr8(8'hcc, 8'h01);
		#1 cmp16(16'(channel_irq_out), 16'h0000);
		$display("test capture done");
		wr8(8'hcc, 8'h04);
		rd8(8'hcc, d);
		cmp16(16'(d[2]), 16'h0000);
		v = pins.cnt_r + 16'h0040;
		wr16(8'hd2, v);
		for (int k = 0; k < 100 && compare_match_out[2] !== 1'b1; k++)
			@(negedge clock_in);
		cmp16(free_running_counter_out, v);
		rd8(8'hcc, d);
		cmp16(16'(d[2]), 16'h0001);
		$display("test compare done");
		// fast clear: upper read of a capture channel, lower write of a compare channel
		wr8(8'hc6, 8'h10);
		rd8(8'hc6, d);
		cmp16(16'(d), 16'h0010);
		wr8(8'hc9, 8'h01);
		pins.pulse(0, 3, r, f);
		repeat (5) @(posedge clock_in);
		rd8(8'hcc, d);
		cmp16(16'(d[0]), 16'h0001);
		rd16(8'hce, v);
		cmp16(v, r);
		wr16(8'hd2, 16'hffff);
		rd8(8'hcc, d);
		cmp16(16'(d), 16'h0000);
		wr8(8'hc6, 8'h00);
		$display("test fast clear done");
		// delta over 256 cycles once the new divisor is loaded
		for (int s = 0; s < 8; s++) begin
			wr8(8'hcb, 8'(s));
			rd8(8'hcb, d);
			cmp16(16'(d), 16'(s));
			repeat (256) @(posedge clock_in);
			#1 v = free_running_counter_out;
			repeat (256) @(posedge clock_in);
			#1 cmp16(free_running_counter_out - v, 16'(256 >> s));
		end
		$display("test prescale done");
		final_report();
	end
endmodule : tb
